// ===== stop_seq_pkg.sv
// package: constants, codes and carrier types of the stop-response sequencer
package stop_seq_pkg;
    // ============================================================
    // timing
    localparam int CLK_FREQ_HZ = 200_000_000;
    localparam int TICK_PERIOD_US = 1000;
    localparam int TICK_CYCLES = CLK_FREQ_HZ / 1_000_000 * TICK_PERIOD_US;
    localparam logic [15:0] TIMER_DEFAULT_MS = 16'h0064;
    localparam logic [15:0] XCHECK_MAX_MS = 16'hEA60;
    localparam logic [15:0] PULSE_MAX_MS = 16'h2710;
    localparam logic [15:0] ACC_MIN_MS = 16'h1388;
    localparam logic [15:0] ACC_MAX_MS = 16'h2710;
    // ============================================================
    // selector codes
    localparam logic [3:0] SEL_PER_LIMIT = 4'h5;
    localparam logic [3:0] POS_SEL_DEFAULT = 4'h2;
    localparam logic [3:0] SPEED_SEL_DEFAULT = 4'h5;
    localparam logic [7:0] ACC_REQ_ON = 8'hAC;
    localparam logic [7:0] ACC_REQ_OFF = 8'h00;
    localparam logic [7:0] ACC_ST_INACTIVE = 8'h00;
    localparam logic [7:0] ACC_ST_ALARM = 8'h0C;
    localparam logic [7:0] ACC_ST_BADCODE = 8'h0D;
    localparam logic [7:0] ACC_ST_EXPIRED = 8'h0F;
    localparam logic [7:0] ACC_ST_ACTIVE = 8'hAC;
    // ============================================================
    // stop responses, listed by rising priority except SOS, which ranks just above none
    typedef enum logic [2:0] {
        RESP_NONE = 3'h0,
        RESP_RETRACT = 3'h1,
        RESP_PATH = 3'h3,
        RESP_HOLD = 3'h2,
        RESP_XCHECK = 3'h6,
        RESP_BRAKED = 3'h7,
        RESP_IMMED = 3'h5,
        RESP_SOS = 3'h4
    } resp_t;
    // parameters latched at power-on
    typedef struct packed {
        logic [15:0] retract_ms;
        logic [15:0] path_ms;
        logic [15:0] hold_ms;
        logic [15:0] xcheck_ms;
        logic [15:0] pulse_off_ms;
        logic [15:0] pulse_check_ms;
        logic [15:0] acc_test_ms;
        logic [15:0] shutdown_speed;
        logic [3:0] speed_sel;
        logic [3:0] pos_sel;
        logic [15:0] limit_sel;
    } cfg_t;
endpackage

// ===== stop_seq.sv
// safety stop-response sequencer for one axis
// Behaviour
// - extended-retract timer expiry moves axis into safe operating stop
// - after standstill timer, supervise stop; still moving escalates to pulse-off
// - crosscheck-fault timer expiry escalates to braked-then-pulse-off
// - braked pulse-off cancels pulses by the programmed delay at latest
// - standstill during braked pulse-off cancels pulses early
// - zero pulse-off delay goes straight to immediate pulse-off
// - test-stop starts pulse check; pulses still on at expiry trips immediate
// - pulses found off at expiry raise pulses-cancelled output
// - acceptance test timer loads programmed start value, supervises mode
// - standstill means speed below programmed shutdown threshold
// - standstill during braked pulse-off activates immediate pulse-off
// - speed violation uses general selector 0..4, value 5 defers
// - limit position violation uses selector 2, 3 or 4
// - per-limit codes 0..4 map to the five responses
// - per-limit codes used only when general selector equals 5
// - test state reports 0, 0xC, 0xD, 0xF or 0xAC
`timescale 1ns/1ps
module stop_seq #(
    parameter int TICK_CYCLES = stop_seq_pkg::TICK_CYCLES
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // parameters, latched on the first clock after reset
    input wire stop_seq_pkg::cfg_t cfg_in,
    // monitoring channels (asynchronous)
    input wire logic speed_violation,
    input wire logic [3:0] speed_limit_hit,
    input wire logic pos_violation,
    input wire logic crosscheck_fault,
    input wire logic [15:0] axis_speed,
    input wire logic pulses_off_fb,
    input wire logic power_on_alarm,
    // plc safety inputs
    input wire logic test_stop_select,
    input wire logic [7:0] acceptance_test_request,
    // outputs
    output logic pulse_cancel,
    output stop_seq_pkg::resp_t active_resp,
    output logic pulses_cancelled,
    output logic [7:0] acceptance_test_state
);
    // ============================================================
    // synchronisers
    localparam int SW = 4 + 16 + 6 + 8;
    logic [SW-1:0] sync1, sync2;
    always_ff @(posedge core_clk) begin
        sync1 <= {speed_limit_hit, axis_speed, speed_violation, pos_violation, crosscheck_fault,
                  pulses_off_fb, power_on_alarm, test_stop_select, acceptance_test_request};
        sync2 <= sync1;
    end
    logic [3:0] s_lim;
    logic [15:0] s_speed;
    logic s_sv, s_pv, s_xc, s_poff, s_alarm, s_ts;
    logic [7:0] s_req;
    assign {s_lim, s_speed, s_sv, s_pv, s_xc, s_poff, s_alarm, s_ts} = sync2[SW-1:8];
    assign s_req = sync2[7:0];

    // ============================================================
    // power-on parameter latch
    stop_seq_pkg::cfg_t cfg;
    logic cfg_done;
    always_ff @(posedge core_clk) begin
        if (srst) begin
            cfg_done <= 1'b0;
            cfg <= '0;
        end else if (!cfg_done) begin
            cfg_done <= 1'b1;
            cfg <= cfg_in;
        end
    end

    // millisecond tick
    logic [31:0] tick_cnt;
    logic tick;
    always_ff @(posedge core_clk) begin
        if (srst || tick_cnt == 32'(TICK_CYCLES - 1)) begin
            tick_cnt <= '0;
        end else begin
            tick_cnt <= tick_cnt + 32'h1;
        end
    end
    assign tick = (tick_cnt == 32'(TICK_CYCLES - 1));

    // ============================================================
    // selector decode, used for general and per-limit codes
    function automatic stop_seq_pkg::resp_t code_to_resp(input logic [3:0] code);
        unique case (code)
            4'h0: code_to_resp = stop_seq_pkg::RESP_IMMED;
            4'h1: code_to_resp = stop_seq_pkg::RESP_BRAKED;
            4'h2: code_to_resp = stop_seq_pkg::RESP_HOLD;
            4'h3: code_to_resp = stop_seq_pkg::RESP_PATH;
            4'h4: code_to_resp = stop_seq_pkg::RESP_RETRACT;
            default: code_to_resp = stop_seq_pkg::RESP_HOLD;
        endcase
    endfunction
    function automatic logic [2:0] rank(input stop_seq_pkg::resp_t r);
        unique case (r)
            stop_seq_pkg::RESP_NONE: rank = 3'h0;
            stop_seq_pkg::RESP_SOS: rank = 3'h1;
            stop_seq_pkg::RESP_RETRACT: rank = 3'h2;
            stop_seq_pkg::RESP_PATH: rank = 3'h3;
            stop_seq_pkg::RESP_HOLD: rank = 3'h4;
            stop_seq_pkg::RESP_XCHECK: rank = 3'h5;
            stop_seq_pkg::RESP_BRAKED: rank = 3'h6;
            stop_seq_pkg::RESP_IMMED: rank = 3'h7;
        endcase
    endfunction

    // highest requested response from the monitors this cycle
    stop_seq_pkg::resp_t req_resp, lim_resp, want_resp;
    logic standstill, timer_done, pchk_trip, resp_tick;
    always_comb begin
        lim_resp = stop_seq_pkg::RESP_NONE;
        for (int i = 0; i < 4; i++) begin
            if (s_lim[i] && rank(code_to_resp(cfg.limit_sel[4*i +: 4])) > rank(lim_resp)) begin
                lim_resp = code_to_resp(cfg.limit_sel[4*i +: 4]);
            end
        end
        req_resp = stop_seq_pkg::RESP_NONE;
        if (s_pv && rank(code_to_resp(cfg.pos_sel)) > rank(req_resp)) begin
            req_resp = code_to_resp(cfg.pos_sel);
        end
        if (s_sv) begin
            if (cfg.speed_sel == stop_seq_pkg::SEL_PER_LIMIT) begin
                if (rank(lim_resp) > rank(req_resp)) req_resp = lim_resp;
            end else if (rank(code_to_resp(cfg.speed_sel)) > rank(req_resp)) begin
                req_resp = code_to_resp(cfg.speed_sel);
            end
        end
        if (s_xc && rank(stop_seq_pkg::RESP_XCHECK) > rank(req_resp)) req_resp = stop_seq_pkg::RESP_XCHECK;
        if (pchk_trip) req_resp = stop_seq_pkg::RESP_IMMED;
        want_resp = req_resp;
        if (active_resp == stop_seq_pkg::RESP_SOS && !standstill && rank(req_resp) < 3'h6) begin
            want_resp = stop_seq_pkg::RESP_BRAKED;
        end
    end

    // ============================================================
    // response state and transition timer
    logic [15:0] resp_ms;
    logic [31:0] resp_sub;
    logic [2:0] peak_rank, served_rank;
    assign standstill = s_speed < cfg.shutdown_speed;
    // a taken response is not restarted by its own violation after handing over to safe stop
    assign served_rank = (rank(active_resp) > peak_rank) ? rank(active_resp) : peak_rank;
    assign resp_tick = (resp_sub == 32'(TICK_CYCLES - 1)); // ms phase restarts with each newly taken response and at the crosscheck hand-over to braked
    always_comb begin
        unique case (active_resp)
            stop_seq_pkg::RESP_RETRACT: timer_done = resp_ms >= cfg.retract_ms;
            stop_seq_pkg::RESP_PATH: timer_done = resp_ms >= cfg.path_ms;
            stop_seq_pkg::RESP_HOLD: timer_done = resp_ms >= cfg.hold_ms;
            stop_seq_pkg::RESP_XCHECK: timer_done = resp_ms >= cfg.xcheck_ms;
            stop_seq_pkg::RESP_BRAKED: timer_done = resp_ms >= cfg.pulse_off_ms;
            default: timer_done = 1'b0;
        endcase
    end
    always_ff @(posedge core_clk) begin
        if (srst || !cfg_done) begin
            active_resp <= stop_seq_pkg::RESP_NONE;
            resp_ms <= '0;
            resp_sub <= '0;
            peak_rank <= 3'h0;
        end else if (rank(want_resp) > served_rank) begin
            active_resp <= want_resp;
            resp_ms <= '0;
            resp_sub <= '0;
            peak_rank <= served_rank;
        end else begin
            peak_rank <= served_rank;
            resp_sub <= resp_tick ? 32'h0 : resp_sub + 32'h1;
            if (resp_tick && resp_ms != 16'hFFFF) resp_ms <= resp_ms + 16'h1;
            unique case (active_resp)
                stop_seq_pkg::RESP_RETRACT, stop_seq_pkg::RESP_PATH, stop_seq_pkg::RESP_HOLD: begin
                    if (timer_done) active_resp <= stop_seq_pkg::RESP_SOS;
                end
                stop_seq_pkg::RESP_XCHECK: begin
                    if (timer_done) begin
                        active_resp <= stop_seq_pkg::RESP_BRAKED;
                        resp_ms <= '0;
                        resp_sub <= '0;
                    end
                end
                stop_seq_pkg::RESP_BRAKED: begin
                    // zero delay means timer_done at once, so this also covers the direct path
                    if (timer_done || standstill) active_resp <= stop_seq_pkg::RESP_IMMED;
                end
                default: begin
                end
            endcase
        end
    end

    // pulse cancellation output
    always_ff @(posedge core_clk) begin
        if (srst) pulse_cancel <= 1'b0;
        else pulse_cancel <= (active_resp == stop_seq_pkg::RESP_IMMED);
    end

    // ============================================================
    // test-stop pulse check
    logic [15:0] pchk_ms;
    logic pchk_run;
    assign pchk_trip = pchk_run && pchk_ms >= cfg.pulse_check_ms && !s_poff;
    always_ff @(posedge core_clk) begin
        if (srst || !cfg_done) begin
            pchk_run <= 1'b0;
            pchk_ms <= '0;
            pulses_cancelled <= 1'b0;
        end else if (!s_ts) begin
            pchk_run <= 1'b0;
            pchk_ms <= '0;
            pulses_cancelled <= 1'b0;
        end else if (!pchk_run && !pulses_cancelled) begin
            pchk_run <= 1'b1;
            pchk_ms <= '0;
        end else if (pchk_run && pchk_ms >= cfg.pulse_check_ms) begin
            pchk_run <= 1'b0;
            pulses_cancelled <= s_poff;
        end else if (pchk_run && tick) begin
            pchk_ms <= pchk_ms + 16'h1;
        end
    end

    // ============================================================
    // acceptance test mode supervision
    logic [15:0] acc_ms;
    logic [7:0] prev_req;
    always_ff @(posedge core_clk) begin
        if (srst || !cfg_done) begin
            acceptance_test_state <= stop_seq_pkg::ACC_ST_INACTIVE;
            acc_ms <= '0;
            prev_req <= stop_seq_pkg::ACC_REQ_OFF;
        end else begin
            prev_req <= s_req;
            if (s_req == stop_seq_pkg::ACC_REQ_OFF) begin // leave and acknowledge
                acceptance_test_state <= stop_seq_pkg::ACC_ST_INACTIVE;
            end else if (s_req != prev_req) begin
                if (s_req != stop_seq_pkg::ACC_REQ_ON) begin
                    acceptance_test_state <= stop_seq_pkg::ACC_ST_BADCODE;
                end else if (s_alarm) begin
                    acceptance_test_state <= stop_seq_pkg::ACC_ST_ALARM;
                end else begin
                    acceptance_test_state <= stop_seq_pkg::ACC_ST_ACTIVE;
                    acc_ms <= cfg.acc_test_ms;
                end
            end else if (acceptance_test_state == stop_seq_pkg::ACC_ST_ACTIVE) begin
                if (acc_ms == 16'h0) acceptance_test_state <= stop_seq_pkg::ACC_ST_EXPIRED;
                else if (tick) acc_ms <= acc_ms - 16'h1;
            end
        end
    end

    // ============================================================
    // checks
    xcheck_escal_a: assert property (@(posedge core_clk) disable iff (srst)
        active_resp == stop_seq_pkg::RESP_XCHECK && timer_done && rank(req_resp) <= 3'h5
        |=> active_resp == stop_seq_pkg::RESP_BRAKED)
        else $error("crosscheck timer did not escalate");
    retract_sos_a: assert property (@(posedge core_clk) disable iff (srst)
        active_resp == stop_seq_pkg::RESP_RETRACT && timer_done && rank(want_resp) <= served_rank
        |=> active_resp == stop_seq_pkg::RESP_SOS)
        else $error("retract timer did not reach safe stop");
    sos_escal_a: assert property (@(posedge core_clk) disable iff (srst)
        active_resp == stop_seq_pkg::RESP_SOS && !standstill |=> rank(active_resp) >= 3'h6)
        else $error("moving axis in safe stop not escalated");
    braked_timeout_a: assert property (@(posedge core_clk) disable iff (srst)
        active_resp == stop_seq_pkg::RESP_BRAKED && timer_done |=> ##1 pulse_cancel)
        else $error("pulses not cancelled after delay");
    standstill_off_a: assert property (@(posedge core_clk) disable iff (srst)
        active_resp == stop_seq_pkg::RESP_BRAKED && standstill |=> active_resp == stop_seq_pkg::RESP_IMMED)
        else $error("standstill did not cancel pulses");
    zero_delay_a: assert property (@(posedge core_clk) disable iff (srst)
        active_resp == stop_seq_pkg::RESP_BRAKED && cfg.pulse_off_ms == 16'h0
        |=> active_resp == stop_seq_pkg::RESP_IMMED)
        else $error("zero delay not immediate");
    pchk_trip_a: assert property (@(posedge core_clk) disable iff (srst)
        pchk_trip |=> active_resp == stop_seq_pkg::RESP_IMMED)
        else $error("pulse check failure not tripped");
    no_demote_a: assert property (@(posedge core_clk) disable iff (srst || !cfg_done)
        active_resp == stop_seq_pkg::RESP_IMMED |=> active_resp == stop_seq_pkg::RESP_IMMED)
        else $error("immediate response replaced");
    per_limit_a: assert property (@(posedge core_clk) disable iff (srst)
        s_sv && !s_pv && !s_xc && !pchk_trip && cfg.speed_sel != stop_seq_pkg::SEL_PER_LIMIT
        |-> req_resp == code_to_resp(cfg.speed_sel))
        else $error("per-limit setting used without selector 5");
    acc_alarm_a: assert property (@(posedge core_clk) disable iff (srst || !cfg_done)
        s_req == stop_seq_pkg::ACC_REQ_ON && $changed(s_req) && s_alarm
        |=> acceptance_test_state == stop_seq_pkg::ACC_ST_ALARM)
        else $error("test mode not refused under alarm");
endmodule

// ===== plc_model.sv
// plc-side partner model: drives the safety inputs and reads back the pulses-cancelled output
`timescale 1ns/1ps
module plc_model (
    // clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // commands from the bench
    input wire logic test_req,
    input wire logic [7:0] acc_cmd,
    // safety output read back
    input wire logic pulses_cancelled,
    // safety inputs driven
    output logic test_stop_select,
    output logic [7:0] acceptance_test_request
);
    // ============================================================
    // stop selection
    // once requested, the selection is only dropped after the pulses-cancelled answer
    always_ff @(posedge core_clk) begin
        if (srst) begin
            test_stop_select <= 1'b0;
        end else if (test_req) begin
            test_stop_select <= 1'b1;
        end else if (pulses_cancelled) begin
            test_stop_select <= 1'b0;
        end
    end
    // test-mode request code, registered like any plc output
    always_ff @(posedge core_clk) begin
        if (srst) begin
            acceptance_test_request <= 8'h00;
        end else begin
            acceptance_test_request <= acc_cmd;
        end
    end
endmodule

// ===== safety_stop_escalation_sequencer_tb_top.sv
// self-checking bench for the stop-response sequencer and its plc model
`timescale 1ns/1ps
module safety_stop_escalation_sequencer_tb_top;
    // short tick so the millisecond timers stay cheap to simulate
    localparam int TICK = 4;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    stop_seq_pkg::cfg_t cfg;
    logic speed_violation, pos_violation, crosscheck_fault, pulses_off_fb, power_on_alarm, test_req;
    logic [3:0] speed_limit_hit;
    logic [15:0] axis_speed;
    logic [7:0] acc_cmd, acceptance_test_request, acceptance_test_state;
    logic test_stop_select, pulse_cancel, pulses_cancelled;
    stop_seq_pkg::resp_t active_resp;
    int bad_count = 0;
    int tests_run = 0;
    int n;
    // ============================================================
    // clock and instances
    initial begin
        forever #2.5 core_clk = ~core_clk;
    end
    stop_seq #(.TICK_CYCLES(TICK)) dut (.core_clk(core_clk), .srst(srst), .cfg_in(cfg),
        .speed_violation(speed_violation), .speed_limit_hit(speed_limit_hit), .pos_violation(pos_violation),
        .crosscheck_fault(crosscheck_fault), .axis_speed(axis_speed), .pulses_off_fb(pulses_off_fb),
        .power_on_alarm(power_on_alarm), .test_stop_select(test_stop_select),
        .acceptance_test_request(acceptance_test_request), .pulse_cancel(pulse_cancel), .active_resp(active_resp),
        .pulses_cancelled(pulses_cancelled), .acceptance_test_state(acceptance_test_state));
    plc_model plc (.core_clk(core_clk), .srst(srst), .test_req(test_req), .acc_cmd(acc_cmd),
        .pulses_cancelled(pulses_cancelled), .test_stop_select(test_stop_select),
        .acceptance_test_request(acceptance_test_request));
    // ============================================================
    // helpers
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic check_range(input int got, input int lo, input int hi);
        tests_run++;
        if (got < lo || got > hi) begin
            bad_count++;
            $display("unexpected delay at %0t: got %h expected %h to %h", $time, got, lo, hi);
        end
    endtask
    function automatic logic [7:0] probe(input int sel);
        case (sel)
            0: return {5'h00, active_resp};
            1: return {7'h00, pulses_cancelled};
            2: return acceptance_test_state;
            default: return {7'h00, pulse_cancel};
        endcase
    endfunction
    // inputs always move one nanosecond after the rising edge
    task automatic step(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask
    // bounded wait; n keeps the cycles taken, a timeout ends the run
    task automatic wait_for(input int sel, input logic [7:0] exp, input int limit);
        tests_run++;
        n = 0;
        while (probe(sel) !== exp) begin
            if (n >= limit) begin
                bad_count++;
                $display("unexpected value at %0t: got %h expected %h", $time, probe(sel), exp);
                finish_test();
            end
            step(1);
            n++;
        end
    endtask
    task automatic wait_resp(input stop_seq_pkg::resp_t r, input int limit);
        wait_for(0, {5'h00, r}, limit);
    endtask
    // parameters only latch after reset, so every configuration needs a fresh reset
    task automatic restart(input logic [3:0] ssel = stop_seq_pkg::SPEED_SEL_DEFAULT, input logic [3:0] psel = 4'h2,
        input logic [15:0] lsel = 16'h2222, input logic [15:0] poff = 16'h0005);
        srst = 1'b1;
        {speed_violation, pos_violation, crosscheck_fault, pulses_off_fb, power_on_alarm, test_req} = 6'h00;
        speed_limit_hit = 4'h0;
        acc_cmd = 8'h00;
        axis_speed = 16'h0100;
        cfg = '{16'h0003, 16'h0003, 16'h0003, 16'h0003, poff, 16'h0003, stop_seq_pkg::ACC_MIN_MS, 16'h0010,
            ssel, psel, lsel};
        step(8);
        srst = 1'b0;
        step(3);
    endtask
    // ============================================================
    // scenarios
    // general selector; per-limit code 0 would give immediate if wrongly used
    task automatic sc_general_sel();
        stop_seq_pkg::resp_t tbl[4] = '{stop_seq_pkg::RESP_IMMED, stop_seq_pkg::RESP_BRAKED,
            stop_seq_pkg::RESP_HOLD, stop_seq_pkg::RESP_PATH};
        for (int i = 0; i < 4; i++) begin
            restart(4'(i), 4'h2, 16'h0000);
            speed_violation = 1'b1;
            speed_limit_hit = 4'h2;
            wait_resp(tbl[i], 5);
        end
    endtask
    // each per-limit code on its own limit, code 4 back on limit 0
    task automatic sc_per_limit();
        stop_seq_pkg::resp_t tbl[5] = '{stop_seq_pkg::RESP_IMMED, stop_seq_pkg::RESP_BRAKED,
            stop_seq_pkg::RESP_HOLD, stop_seq_pkg::RESP_PATH, stop_seq_pkg::RESP_RETRACT};
        for (int k = 0; k < 5; k++) begin
            restart(stop_seq_pkg::SEL_PER_LIMIT, 4'h2, 16'(k) << (4 * (k % 4)));
            speed_violation = 1'b1;
            speed_limit_hit = 4'h1 << (k % 4);
            wait_resp(tbl[k], 5);
        end
    endtask
    // limit-position codes, timed hand-over into safe stop, axis at rest stays there
    task automatic sc_pos_sel();
        stop_seq_pkg::resp_t tbl[3] = '{stop_seq_pkg::RESP_HOLD, stop_seq_pkg::RESP_PATH, stop_seq_pkg::RESP_RETRACT};
        for (int k = 0; k < 3; k++) begin
            restart(stop_seq_pkg::SPEED_SEL_DEFAULT, 4'(k + 2));
            axis_speed = 16'h0000;
            pos_violation = 1'b1;
            wait_resp(tbl[k], 5);
            wait_resp(stop_seq_pkg::RESP_SOS, 30);
            check_range(n, 3 * TICK + 1, 3 * TICK + 1);
            step(10);
            wait_resp(stop_seq_pkg::RESP_SOS, 0);
        end
    endtask
    // speed equal to the threshold still counts as moving
    task automatic sc_moving();
        restart();
        axis_speed = 16'h0010;
        pos_violation = 1'b1;
        wait_resp(stop_seq_pkg::RESP_SOS, 30);
        wait_resp(stop_seq_pkg::RESP_BRAKED, 4);
        axis_speed = 16'h000F;
        wait_resp(stop_seq_pkg::RESP_IMMED, 5);
        wait_for(3, 8'h01, 2);
        crosscheck_fault = 1'b1;
        step(8);
        wait_resp(stop_seq_pkg::RESP_IMMED, 0);
    endtask
    task automatic sc_xcheck();
        restart();
        crosscheck_fault = 1'b1;
        wait_resp(stop_seq_pkg::RESP_XCHECK, 5);
        wait_resp(stop_seq_pkg::RESP_BRAKED, 30);
        check_range(n, 3 * TICK + 1, 3 * TICK + 1);
        wait_resp(stop_seq_pkg::RESP_IMMED, 40);
        check_range(n, 5 * TICK + 1, 5 * TICK + 1);
        wait_for(3, 8'h01, 2);
    endtask
    task automatic sc_zero_delay();
        restart(4'h1, 4'h2, 16'h2222, 16'h0000);
        speed_violation = 1'b1;
        speed_limit_hit = 4'h1;
        wait_resp(stop_seq_pkg::RESP_IMMED, 6);
        wait_for(3, 8'h01, 2);
    endtask
    // pulse check passing, then failing with the power stage still on
    task automatic sc_test_stop();
        restart();
        pulses_off_fb = 1'b1;
        test_req = 1'b1;
        step(1);
        test_req = 1'b0;
        wait_for(1, 8'h01, 30);
        check_range(n, 2 * TICK, 4 * TICK + 5);
        wait_resp(stop_seq_pkg::RESP_NONE, 0);
        wait_for(1, 8'h00, 6);
        restart();
        test_req = 1'b1;
        wait_resp(stop_seq_pkg::RESP_IMMED, 30);
        check_range(n, 2 * TICK, 4 * TICK + 6);
        wait_for(1, 8'h00, 0);
    endtask
    task automatic sc_accept();
        restart();
        acc_cmd = stop_seq_pkg::ACC_REQ_ON;
        wait_for(2, stop_seq_pkg::ACC_ST_ACTIVE, 6);
        wait_for(2, stop_seq_pkg::ACC_ST_EXPIRED, 21000);
        check_range(n, (int'(stop_seq_pkg::ACC_MIN_MS) - 1) * TICK, (int'(stop_seq_pkg::ACC_MIN_MS) + 1) * TICK);
        acc_cmd = stop_seq_pkg::ACC_REQ_OFF;
        wait_for(2, stop_seq_pkg::ACC_ST_INACTIVE, 6);
        acc_cmd = 8'h55;
        wait_for(2, stop_seq_pkg::ACC_ST_BADCODE, 6);
        acc_cmd = stop_seq_pkg::ACC_REQ_OFF;
        step(6);
        power_on_alarm = 1'b1;
        acc_cmd = stop_seq_pkg::ACC_REQ_ON;
        wait_for(2, stop_seq_pkg::ACC_ST_ALARM, 6);
    endtask
    // ============================================================
    // main sequence
    initial begin
        restart();
        sc_general_sel();
        sc_per_limit();
        sc_pos_sel();
        sc_moving();
        sc_xcheck();
        sc_zero_delay();
        sc_test_stop();
        sc_accept();
        finish_test();
    end
endmodule
